// ---- tca_params.svh ----
// Purpose: constants of the time-multiplexed command and audio slave port
// Assumes: included by bare name, after the package
// Notes:   positions are bit numbers within a 32-bit packet
`ifndef TCA_PARAMS_SVH
`define TCA_PARAMS_SVH

// ********************************
// packet fields
// ********************************
`define TCA_BIT_LAST   5'd31
`define TCA_BIT_EXT    30
`define TCA_BIT_DCS    29
`define TCA_BIT_ID_HI  28
`define TCA_BIT_ID_LO  24
`define TCA_BIT_RD     23
`define TCA_BIT_RID_HI 22
`define TCA_BIT_RID_LO 16
`define TCA_BIT_DAT_HI 15
`define TCA_BIT_DAT_LO 8
`define TCA_HDR_BASE   17
`define TCA_ID_BCAST   5'h1f
`define TCA_ID_NONE    5'h00

// ********************************
// bit counts within a packet
// ********************************
`define TCA_CNT_HDR    5'd14
`define TCA_CNT_RID    5'd15
`define TCA_CNT_OE     5'd15
`define TCA_CNT_DFIRST 5'd16
`define TCA_CNT_DLAST  5'd23
`define TCA_CNT_REL    5'd24
`define TCA_RD_OFS     5'd23

// ********************************
// mode entry
// ********************************
`define TCA_SYNC_W     3'd2
`define TCA_MODE_FRM   2'd1

// ********************************
// registers
// ********************************
`define TCA_REG_CHEN   7'd9
`define TCA_REG_DEVID  7'd17
`define TCA_REG_RST    8'h00
`define TCA_CHEN_RST   8'h00
`define TCA_DEVID_RST  8'h01
`define TCA_WB_STAT    10'h200
`define TCA_WB_REGSEL  9
`define TCA_NCH        8

`endif

// ---- tca_pkg.sv ----
// Purpose: types of the time-multiplexed command and audio slave port
// Assumes: nothing
// Notes:   no constants here; see tca_params.svh
package tca_pkg;

	typedef enum logic [1:0] {
		PK_CMD = 2'b00,
		PK_EXT = 2'b01,
		PK_AUD = 2'b10
	} pkt_t;

	typedef struct packed {
		logic        valid;
		logic [2:0]  chan;
		logic [31:0] sample;
	} audio_t;

	typedef struct packed {
		logic fs;
		logic bck;
		logic sdi;
		logic tok;
	} pins_t;

endpackage

// ---- tca_slave_port.sv ----
// Purpose: slave port of a time-multiplexed command and audio serial link
// Assumes: CLK_I at 200 MHz, link pins asynchronous, bit clock much slower
// Notes:   registers reached over classic Wishbone; one audio word per own slot
//
// Overview of operation
// [RULE1] bit 23 high means register read, low means register write
// [RULE2] register id taken from bits 22..16 of command and extended packets
// [RULE3] data byte in bits 15..8 is written to the addressed register
// [RULE4] low byte ignored; nothing driven there on a read
// [RULE5] extended packets decode like commands; bit 31 reserved
// [RULE6] audio packets are 32 bits, msb first, sample at bit 31
// [RULE7] host pads short samples with zeros
// [RULE8] register 9 holds channel enables, register 17 the chain id; the code reads register 9 active-low, a set bit disables its channel
// [RULE9] read data shifts out during the data byte of the same packet
// [RULE10] serial input sampled on rising bit clock edges
// [RULE11] read-back output changes on falling bit clock edges
// [RULE12] read-back driver enabled one bit clock before first data bit
// [RULE13] token output high during this device's last audio slot
// [RULE14] token input high means the next slot belongs to this device
// [RULE15] no active channel: token input passed to token output
// [RULE16] host starts clocks, enters mode, assigns ids, then runs audio
// [RULE17] mode entered after two frames with a two-clock sync pulse
// [RULE18] commands acted on only when chain select bit 29 is low
// [RULE19] id 0x1f is a broadcast write; id 0x00 selects nobody
// [RULE20] extended packets follow the command and the frame has no audio
// [RULE21] read-back output is off except during an own read
// [RULE22] commands for another id, and non-broadcast, are ignored
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "tca_params.svh"

module tca_slave_port (
	// clock and reset
	input  wire logic            CLK_I,
	input  wire logic            RST_B_I,
	// wishbone slave
	input  wire logic            CYC_I,
	input  wire logic            STB_I,
	input  wire logic            WE_I,
	input  wire logic [9:0]      ADR_I,
	input  wire logic [3:0]      SEL_I,
	input  wire logic [31:0]     DAT_I,
	output logic      [31:0]     DAT_O,
	output logic                 ACK_O,
	// serial link
	input  wire logic            FRAME_SYNC_IN_I,
	input  wire logic            SERIAL_BIT_CLOCK_I,
	input  wire logic            SERIAL_CMD_AUDIO_IN_I,
	output logic                 READBACK_OUT_O,
	output logic                 READBACK_OE_O,
	// daisy chain
	input  wire logic            CHAIN_TOKEN_IN_I,
	output logic                 CHAIN_TOKEN_OUT_O,
	// received audio and mode
	output var tca_pkg::audio_t  AUDIO_O,
	output logic                 TDM_MODE_O
);

	// ********************************
	// decoding helpers
	// ********************************
	function automatic logic [3:0] count_ones(input logic [7:0] m);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < `TCA_NCH; i++) begin
			n = n + {3'h0, m[i]};
		end
		return n;
	endfunction

	function automatic logic [2:0] nth_active(input logic [7:0] m, input logic [3:0] k);
		logic [3:0] n;
		logic [2:0] c;
		n = 4'h0;
		c = 3'h0;
		for (int i = 0; i < `TCA_NCH; i++) begin
			if (m[i]) begin
				if (n == k) begin
					c = 3'(i);
				end
				n = n + 4'h1;
			end
		end
		return c;
	endfunction

	function automatic logic id_hit(input logic [4:0] id, input logic [4:0] own,
	                                input logic wr);
		return (id != `TCA_ID_NONE) && ((id == own) || (wr && id == `TCA_ID_BCAST));
	endfunction

	// ********************************
	// pin synchronisers
	// ********************************
	logic [3:0]      pin_raw;
	logic [3:0]      pin_s1;
	logic [3:0]      pin_s2;
	tca_pkg::pins_t  pins;
	logic            bck_d;
	logic            bck_rise;
	logic            bck_fall;

	assign pin_raw = {FRAME_SYNC_IN_I, SERIAL_BIT_CLOCK_I, SERIAL_CMD_AUDIO_IN_I,
	                  CHAIN_TOKEN_IN_I};

	for (genvar gi = 0; gi < 4; gi++) begin : g_sync
		always_ff @(posedge CLK_I or negedge RST_B_I) begin
			if (!RST_B_I) begin
				pin_s1[gi] <= 1'b0;
				pin_s2[gi] <= 1'b0;
			end else begin
				pin_s1[gi] <= pin_raw[gi];
				pin_s2[gi] <= pin_s1[gi];
			end
		end
	end

	assign pins = tca_pkg::pins_t'(pin_s2);

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			bck_d <= 1'b0;
		end else begin
			bck_d <= pins.bck;
		end
	end

	assign bck_rise = pins.bck & ~bck_d; // [RULE10]
	assign bck_fall = ~pins.bck & bck_d; // [RULE11]

	// ********************************
	// register file
	// ********************************
	logic [7:0]  regs [0:127];
	logic [4:0]  own_id;
	logic [7:0]  active;
	logic [3:0]  n_act;

	assign own_id = regs[`TCA_REG_DEVID][4:0]; // [RULE8]
	assign active = ~regs[`TCA_REG_CHEN];      // [RULE8]
	assign n_act  = count_ones(active);

	// ********************************
	// mode entry
	// ********************************
	logic        fs_prev;
	logic [2:0]  fs_hi_cnt;
	logic [1:0]  good_frm;
	logic        tdm_mode;
	logic        frame_start;

	assign frame_start = bck_rise & pins.fs & ~fs_prev;

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			fs_prev   <= 1'b0;
			fs_hi_cnt <= 3'h0;
			good_frm  <= 2'h0;
			tdm_mode  <= 1'b0;
		end else if (bck_rise) begin
			fs_prev <= pins.fs;
			if (pins.fs) begin
				if (fs_hi_cnt != 3'h7) begin
					fs_hi_cnt <= fs_hi_cnt + 3'h1;
				end
			end else begin
				fs_hi_cnt <= 3'h0;
			end
			if (!pins.fs && fs_prev) begin
				if (fs_hi_cnt == `TCA_SYNC_W) begin // [RULE17]
					if (good_frm >= `TCA_MODE_FRM) begin
						tdm_mode <= 1'b1;
					end else begin
						good_frm <= good_frm + 2'h1;
					end
				end else begin
					good_frm <= 2'h0;
					tdm_mode <= 1'b0;
				end
			end
		end
	end

	// ********************************
	// packet receiver
	// ********************************
	logic [4:0]      rx_cnt;
	logic [31:0]     sh;
	logic [31:0]     word;
	logic [14:0]     hdr;
	logic            pkt_end;
	tca_pkg::pkt_t   pkt;
	tca_pkg::pkt_t   next_pkt;
	logic            cmd_ok;
	logic            cmd_wr;

	assign word    = {sh[30:0], pins.sdi};            // [RULE6]
	assign hdr     = {sh[13:0], pins.sdi};
	assign pkt_end = bck_rise & ~frame_start & (rx_cnt == `TCA_BIT_LAST);

	always_comb begin
		case (pkt)
			tca_pkg::PK_CMD: begin
				next_pkt = word[`TCA_BIT_EXT] ? tca_pkg::PK_EXT : tca_pkg::PK_AUD; // [RULE20]
			end
			// once extended packets run, the rest of the frame carries no audio
			tca_pkg::PK_EXT: begin
				next_pkt = tca_pkg::PK_EXT; // [RULE20]
			end
			tca_pkg::PK_AUD: begin
				next_pkt = tca_pkg::PK_AUD;
			end
			default: begin
				next_pkt = tca_pkg::PK_AUD;
			end
		endcase
	end

	// bit 31 is not looked at, so extended packets decode alike
	assign cmd_ok = tdm_mode & (pkt != tca_pkg::PK_AUD)        // [RULE5]
	              & ~word[`TCA_BIT_DCS];                       // [RULE18]
	assign cmd_wr = pkt_end & cmd_ok & ~word[`TCA_BIT_RD]      // [RULE1]
	              & id_hit(word[`TCA_BIT_ID_HI:`TCA_BIT_ID_LO], own_id, 1'b1); // [RULE19] [RULE22]

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rx_cnt <= 5'h0;
			sh     <= 32'h0;
			pkt    <= tca_pkg::PK_AUD;
		end else if (frame_start) begin
			rx_cnt <= 5'h1;
			sh     <= {31'h0, pins.sdi};
			pkt    <= tca_pkg::PK_CMD;
		end else if (bck_rise) begin
			sh <= word;
			if (rx_cnt == `TCA_BIT_LAST) begin
				rx_cnt <= 5'h0;
				pkt    <= next_pkt;
			end else begin
				rx_cnt <= rx_cnt + 5'h1;
			end
		end
	end

	// ********************************
	// read-back output
	// ********************************
	logic        rd_arm;
	logic [7:0]  rd_byte;
	logic        rb_out;
	logic        rb_oe;
	logic [4:0]  rd_idx;

	assign rd_idx = `TCA_RD_OFS - rx_cnt;

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rd_arm  <= 1'b0;
			rd_byte <= 8'h00;
		end else if (frame_start) begin
			rd_arm <= 1'b0;
		end else if (bck_rise && rx_cnt == `TCA_CNT_HDR) begin
			rd_arm <= tdm_mode & (pkt != tca_pkg::PK_AUD)
			        & hdr[`TCA_BIT_RD - `TCA_HDR_BASE]                  // [RULE1]
			        & ~hdr[`TCA_BIT_DCS - `TCA_HDR_BASE]                // [RULE18]
			        & id_hit(hdr[`TCA_BIT_ID_HI - `TCA_HDR_BASE:
			                     `TCA_BIT_ID_LO - `TCA_HDR_BASE], own_id, 1'b0); // [RULE22]
		end else if (bck_rise && rx_cnt == `TCA_CNT_RID) begin
			rd_byte <= regs[{sh[`TCA_BIT_RID_HI - `TCA_HDR_BASE:0], pins.sdi}]; // [RULE2]
		end else if (bck_fall && rx_cnt == `TCA_CNT_REL) begin
			rd_arm <= 1'b0;
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rb_out <= 1'b0;
			rb_oe  <= 1'b0;
		end else if (frame_start || !rd_arm) begin
			rb_out <= 1'b0;
			rb_oe  <= 1'b0; // [RULE21]
		end else if (bck_fall) begin
			if (rx_cnt == `TCA_CNT_OE) begin
				rb_oe  <= 1'b1; // [RULE12]
				rb_out <= 1'b0;
			end else if (rx_cnt >= `TCA_CNT_DFIRST && rx_cnt <= `TCA_CNT_DLAST) begin
				rb_out <= rd_byte[rd_idx[2:0]]; // [RULE9] [RULE11]
			end else if (rx_cnt == `TCA_CNT_REL) begin
				rb_oe  <= 1'b0; // [RULE4]
				rb_out <= 1'b0;
			end
		end
	end

	// ********************************
	// register writes
	// ********************************
	logic        wb_req;
	logic        wb_wr;

	assign wb_req = CYC_I & STB_I & ~ACK_O;
	assign wb_wr  = wb_req & WE_I & SEL_I[0] & ~ADR_I[`TCA_WB_REGSEL];

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			for (int i = 0; i < 128; i++) begin
				regs[i] <= `TCA_REG_RST;
			end
			regs[`TCA_REG_CHEN]  <= `TCA_CHEN_RST;
			regs[`TCA_REG_DEVID] <= `TCA_DEVID_RST;
		end else begin
			if (wb_wr) begin
				regs[ADR_I[8:2]] <= DAT_I[7:0];
			end
			if (cmd_wr) begin
				regs[word[`TCA_BIT_RID_HI:`TCA_BIT_RID_LO]] <=
					word[`TCA_BIT_DAT_HI:`TCA_BIT_DAT_LO]; // [RULE2] [RULE3]
			end
		end
	end

	// ********************************
	// audio slots and chain token
	// ********************************
	logic        tok_seen;
	logic        owning;
	logic        slots_done;
	logic [3:0]  own_cnt;
	logic        tok_out;
	logic        start_own;
	logic        next_owning;
	logic [3:0]  next_own_cnt;
	tca_pkg::audio_t aud;

	assign start_own = ~owning & ~slots_done & (tok_seen | pins.tok)    // [RULE14]
	                 & (n_act != 4'h0) & (next_pkt == tca_pkg::PK_AUD); // [RULE20]
	assign next_owning  = start_own | (owning & (own_cnt + 4'h1 != n_act));
	assign next_own_cnt = start_own ? 4'h0 : own_cnt + 4'h1;

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			tok_seen   <= 1'b0;
			owning     <= 1'b0;
			slots_done <= 1'b0;
			own_cnt    <= 4'h0;
			tok_out    <= 1'b0;
		end else if (frame_start) begin
			tok_seen   <= pins.tok;
			owning     <= 1'b0;
			slots_done <= 1'b0;
			own_cnt    <= 4'h0;
			tok_out    <= (n_act == 4'h0) ? pins.tok : 1'b0;
		end else begin
			if (n_act == 4'h0) begin
				tok_out <= pins.tok; // [RULE15]
			end
			if (bck_rise && pins.tok) begin
				tok_seen <= 1'b1;
			end
			if (pkt_end && tdm_mode) begin
				tok_seen <= 1'b0;
				if (owning && pkt == tca_pkg::PK_AUD) begin
					own_cnt <= next_own_cnt;
					if (!next_owning) begin
						slots_done <= 1'b1;
					end
				end
				if (start_own) begin
					own_cnt <= 4'h0;
				end
				owning <= next_owning & (owning | start_own);
				if (n_act != 4'h0) begin
					tok_out <= next_owning & (next_own_cnt == n_act - 4'h1); // [RULE13]
				end
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			aud <= '0;
		end else begin
			aud.valid <= 1'b0;
			if (pkt_end && tdm_mode && owning && pkt == tca_pkg::PK_AUD) begin
				aud.valid  <= 1'b1;
				aud.chan   <= nth_active(active, own_cnt);
				aud.sample <= word; // [RULE6]
			end
		end
	end

	// ********************************
	// wishbone answer
	// ********************************
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ACK_O <= 1'b0;
			DAT_O <= 32'h0;
		end else begin
			ACK_O <= wb_req;
			if (wb_req) begin
				if (!ADR_I[`TCA_WB_REGSEL]) begin
					DAT_O <= {24'h0, regs[ADR_I[8:2]]};
				end else if (ADR_I == `TCA_WB_STAT) begin
					DAT_O <= {24'h0, n_act, 2'h0, owning, tdm_mode};
				end else begin
					DAT_O <= 32'h0;
				end
			end
		end
	end

	// ********************************
	// outputs
	// ********************************
	assign READBACK_OUT_O    = rb_out;
	assign READBACK_OE_O     = rb_oe;
	assign CHAIN_TOKEN_OUT_O = tok_out;
	assign AUDIO_O           = aud;
	assign TDM_MODE_O        = tdm_mode;

endmodule

`default_nettype wire

// ---- tca_chk.sv ----
// Purpose: pin assertions for the slave port
// Assumes: bit clock much slower than CLK_I
// Notes:   bound to the top module at the foot
`timescale 1ns/100ps
`default_nettype none
module tca_chk (
	// bus side
	input wire logic            CLK_I,
	input wire logic            RST_B_I,
	input wire logic            CYC_I,
	input wire logic            STB_I,
	input wire logic            WE_I,
	input wire logic [9:0]      ADR_I,
	input wire logic [31:0]     DAT_O,
	input wire logic            ACK_O,
	// link side
	input wire logic            FRAME_SYNC_IN_I,
	input wire logic            SERIAL_BIT_CLOCK_I,
	input wire logic            READBACK_OUT_O,
	input wire logic            READBACK_OE_O,
	input wire tca_pkg::audio_t AUDIO_O,
	input wire logic            TDM_MODE_O
);
	logic       bck_q;
	logic [4:0] n_rise;
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (!RST_B_I);
	// ****
	// bit clock rises seen while the driver is on
	// ****
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			bck_q  <= 1'b0;
			n_rise <= 5'h00;
		end else begin
			bck_q  <= SERIAL_BIT_CLOCK_I;
			n_rise <= READBACK_OE_O ? n_rise + 5'(SERIAL_BIT_CLOCK_I & !bck_q) : 5'h00;
		end
	end
	ack_next_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
		else $error("ack late");
	ack_pulse_a: assert property (ACK_O |=> !ACK_O)
		else $error("ack too long");
	rd_upper_a: assert property (ACK_O && !$past(WE_I) |-> DAT_O[31:8] == 24'h000000)
		else $error("read upper bits set");
	rd_unmap_a: assert property (ACK_O && !$past(WE_I) && $past(ADR_I) > 10'h200 |-> DAT_O == 32'h0)
		else $error("unmapped read not zero");
	oe_mode_a: assert property (READBACK_OE_O |-> TDM_MODE_O)
		else $error("driver on outside mode");
	oe_rise_a: assert property ($rose(READBACK_OE_O) |-> !SERIAL_BIT_CLOCK_I)
		else $error("driver on off falling edge");
	out_fall_a: assert property (READBACK_OE_O && $changed(READBACK_OUT_O) |-> !SERIAL_BIT_CLOCK_I)
		else $error("read bit changed on rising half");
	oe_nine_a: assert property ($fell(READBACK_OE_O) |-> n_rise == 5'd9)
		else $error("driver window not nine bits");
	mode_sync_a: assert property ($rose(TDM_MODE_O) |-> !FRAME_SYNC_IN_I)
		else $error("mode set while sync high");
	aud_pulse_a: assert property (AUDIO_O.valid |=> !AUDIO_O.valid)
		else $error("audio valid too long");
	aud_rise_a: assert property ($rose(AUDIO_O.valid) |-> SERIAL_BIT_CLOCK_I && TDM_MODE_O)
		else $error("audio word off rising edge");
	cover property ($rose(TDM_MODE_O));
	cover property ($fell(READBACK_OE_O));
	cover property (AUDIO_O.valid);
endmodule
bind tca_slave_port tca_chk u_chk (.CLK_I, .RST_B_I, .CYC_I, .STB_I, .WE_I, .ADR_I, .DAT_O,
	.ACK_O, .FRAME_SYNC_IN_I, .SERIAL_BIT_CLOCK_I, .READBACK_OUT_O, .READBACK_OE_O,
	.AUDIO_O, .TDM_MODE_O);
`default_nettype wire

// ---- tca_host.sv ----
// Purpose: host model that drives the link pins
// Assumes: 48 ns bit clock, idle low between frames
// Notes:   released read-back line is pulled up
`timescale 1ns/100ps
`default_nettype none
module tca_host (
	// from the port
	input  wire logic          rb_i,
	input  wire logic          rb_oe_i,
	input  wire logic          tok_i,
	// link pins
	output var tca_pkg::pins_t pins_o
);
	logic [31:0] pk [8];
	logic        tin [8];
	logic [31:0] ov;
	logic [31:0] dv;
	logic [7:0]  tk;
	int          pidx;
	initial pins_o = '0;
	// ****
	// one frame of n packets, sync high for w bits
	// ****
	task automatic frame(input int n, input int w);
		for (int p = 0; p < n; p++) begin
			pidx = p;
			for (int b = 31; b >= 0; b--) begin
				pins_o.tok <= tin[p];
				pins_o.sdi <= pk[p][b];
				pins_o.fs <= p == 0 && b > 31 - w;
				#24;
				pins_o.bck <= 1'b1;
				if (p == 0) begin
					ov[b] = rb_oe_i;
					dv[b] = rb_oe_i ? rb_i : 1'b1;
				end
				if (b == 16)
					tk[p] = tok_i;
				#24;
				pins_o.bck <= 1'b0;
			end
		end
		pins_o.sdi <= ~pins_o.sdi;
	endtask
endmodule
`default_nettype wire

// ---- tca_slave_port_tb.sv ----
// Purpose: self-checking bench for the slave port
// Assumes: tca_host drives the link
// Notes:   registers read back over wishbone
`timescale 1ns/100ps
`default_nettype none
module tca_slave_port_tb;
	logic            clk;
	logic            rst_b;
	logic            cyc;
	logic            stb;
	logic            we;
	logic [9:0]      adr;
	logic [31:0]     wdat;
	logic [31:0]     rdat;
	logic            ack;
	logic            rb;
	logic            rb_oe;
	logic            tok;
	logic            mode;
	tca_pkg::pins_t  pins;
	tca_pkg::audio_t aud;
	logic [31:0]     d;
	logic [7:0]      amask;
	logic [7:0]      hi [5] = '{8'h81, 8'h21, 8'h02, 8'h1f, 8'h00};
	int              ofs;
	int              n_aud = 0;
	int              n_errors = 0;
	int              num_checks = 0;
	tca_slave_port uut (.CLK_I(clk), .RST_B_I(rst_b), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
		.ADR_I(adr), .SEL_I(4'hf), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
		.FRAME_SYNC_IN_I(pins.fs), .SERIAL_BIT_CLOCK_I(pins.bck),
		.SERIAL_CMD_AUDIO_IN_I(pins.sdi), .READBACK_OUT_O(rb), .READBACK_OE_O(rb_oe),
		.CHAIN_TOKEN_IN_I(pins.tok), .CHAIN_TOKEN_OUT_O(tok), .AUDIO_O(aud), .TDM_MODE_O(mode));
	tca_host hst (.rb_i(rb), .rb_oe_i(rb_oe), .tok_i(tok), .pins_o(pins));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ****
	// tasks
	// ****
	function automatic logic [31:0] mk(logic [7:0] h, logic r, logic [6:0] g, logic [7:0] v);
		return {h, r, g, v, 8'hc3};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= wd;
		@(posedge clk);
		while (ack !== 1'b1 && k < 20) begin
			k++;
			@(posedge clk);
		end
		chk({31'h0, ack}, 32'h1, "no ack");
		if (ack !== 1'b1)
			print_verdict();
		d = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clk) begin
		if (aud.valid === 1'b1) begin
			n_aud++;
			amask[hst.pidx] = 1'b1;
			chk(aud.sample, {8'(hst.pidx), 16'h5a3c, 8'h00}, "sample");
			chk(aud.chan, hst.pidx - ofs, "channel");
		end
	end
	initial begin
		#300000;
		n_errors++;
		print_verdict();
	end
	// ****
	// tests
	// ****
	initial begin
		rst_b = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 10'h000;
		wdat = 32'h0;
		hst.tin = '{default: 1'b0};
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		wb(0, 10'h044, 0);
		chk(d, 32'h01, "id reset");
		wb(0, 10'h024, 0);
		chk(d, 32'h00, "enable reset");
		wb(0, 10'h3f0, 0);
		chk(d, 32'h00, "unmapped");
		$display("test reset done");
		hst.pk[0] = mk(8'h01, 1'b0, 7'd5, 8'h33);
		repeat (2) hst.frame(1, 4);
		chk(mode, 1'b0, "wide sync");
		hst.pk[0] = 32'h0;
		repeat (2) hst.frame(1, 2);
		chk(mode, 1'b1, "mode entry");
		wb(0, 10'h200, 0);
		chk(d, 32'h81, "status");
		wb(0, 10'h014, 0);
		chk(d, 32'h0, "write before mode");
		$display("test mode done");
		for (int i = 0; i < 5; i++) begin
			hst.pk[0] = mk(hi[i], 1'b0, 7'(5 + i), 8'ha5);
			hst.frame(1, 2);
			wb(0, {1'b0, 7'(5 + i), 2'b00}, 0);
			chk(d, (i == 0 || i == 3) ? 32'ha5 : 32'h0, "write");
		end
		$display("test writes done");
		hst.pk[0] = mk(8'h41, 1'b0, 7'd11, 8'h77);
		hst.pk[1] = mk(8'h01, 1'b0, 7'd12, 8'h66);
		hst.pk[2] = 32'h0;
		hst.tin[1] = 1'b1;
		hst.frame(3, 2);
		hst.tin[1] = 1'b0;
		wb(0, 10'h02c, 0);
		chk(d, 32'h77, "ext lead");
		wb(0, 10'h030, 0);
		chk(d, 32'h66, "ext packet");
		chk(n_aud, 0, "ext audio");
		$display("test extended done");
		wb(1, 10'h00c, 32'h5a);
		hst.pk[0] = mk(8'h01, 1'b1, 7'd3, 8'h00);
		hst.frame(1, 2);
		chk(hst.ov, 32'h0001ff00, "driver window");
		chk(hst.dv[15:8], 32'h5a, "read data");
		hst.pk[0] = mk(8'h1f, 1'b1, 7'd3, 8'h00);
		hst.frame(1, 2);
		chk(hst.ov, 32'h0, "broadcast read");
		wb(0, 10'h00c, 0);
		chk(d, 32'h5a, "read kept reg");
		$display("test read done");
		wb(1, 10'h024, 32'hfc);
		hst.pk[0] = 32'h0;
		for (int p = 1; p < 7; p++) begin
			hst.pk[p] = {8'(p), 16'h5a3c, 8'h00};
			hst.tin[p] = p == 2;
		end
		ofs = 3;
		amask = 8'h00;
		hst.tk = 8'h00;
		hst.frame(7, 2);
		chk(amask, 32'h18, "own slots");
		chk(hst.tk, 32'h10, "token last slot");
		$display("test audio done");
		wb(1, 10'h024, 32'hff);
		hst.tin[0] = 1'b1;
		hst.frame(1, 2);
		chk(hst.tk[0], 32'h1, "token through high");
		hst.tin[0] = 1'b0;
		hst.frame(1, 2);
		chk(hst.tk[0], 32'h0, "token through low");
		$display("test token done");
		print_verdict();
	end
endmodule
`default_nettype wire
